// ==== core/boot_resp.sv ====
// Boot serial responder: baud match, checksum and identification replies
`timescale 1ns/1ps
module boot_resp #(
  parameter int FIFO_DEPTH = 2,
  parameter int MIN_BIT = 4,
  parameter logic [7:0] ROM_SIZE_CODE = 8'h11, // Arbitrary value
  parameter logic [7:0] RSV_A = 8'h22, // Arbitrary value
  parameter logic [7:0] RSV_B = 8'h33, // Arbitrary value
  parameter logic [7:0] RSV_C = 8'h44, // Arbitrary value
  parameter logic [7:0] RSV_D = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Serial link
  input wire logic i_rxd,
  output logic o_txd,
  // Flash checksum from the device
  input wire boot_resp_pkg::flash_sum_t i_flash_sum,
  // Status
  output logic o_locked,
  output logic o_halted
);
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end
  if (MIN_BIT < 2) begin : g_bad_min
    $error("MIN_BIT must be at least 2");
  end
  localparam int PW = $clog2(FIFO_DEPTH);

  boot_resp_pkg::resp_state_t state;
  boot_resp_pkg::reply_kind_t kind;
  logic [4:0] idx;
  logic [7:0] id_acc;
  boot_resp_pkg::flash_sum_t sum_hold;
  logic [7:0] err_code;

  // Input synchroniser
  logic rx_m, rx_s, rx_d;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_d <= 1'b1;
    end else begin
      rx_m <= i_rxd;
      rx_s <= rx_m;
      rx_d <= rx_s;
    end
  end
  wire logic fall = rx_d & ~rx_s;
  wire logic rise = ~rx_d & rx_s;

  // Baud measurement on 0x86: low 2 bits, high 2 bits, low 4 bits
  logic [1:0] meas_ph;
  logic [15:0] meas_cnt, meas_l, meas_h;
  logic [15:0] bit_per;
  logic meas_ok;
  logic [17:0] two_b, half_b, h_lo, h_hi, l2_lo, l2_hi;
  always_comb begin
    two_b = {2'b00, meas_l};
    half_b = {4'h0, meas_l[15:2]};
    h_lo = two_b - half_b;
    h_hi = two_b + half_b;
    l2_lo = {1'b0, meas_l, 1'b0} - {3'h0, meas_l[15:1]};
    l2_hi = {1'b0, meas_l, 1'b0} + {3'h0, meas_l[15:1]};
  end
  wire logic meas_good = ({2'b00, meas_h} >= h_lo) && ({2'b00, meas_h} <= h_hi) &&
                         ({2'b00, meas_cnt} >= l2_lo) && ({2'b00, meas_cnt} <= l2_hi) &&
                         (meas_l >= 16'(2 * MIN_BIT));
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meas_ph <= 2'h0;
      meas_cnt <= 16'h0000;
      meas_l <= 16'h0000;
      meas_h <= 16'h0000;
      meas_ok <= 1'b0;
      bit_per <= boot_resp_pkg::BIT_PERIOD_RST;
    end else begin
      meas_ok <= 1'b0;
      if (state != boot_resp_pkg::ST_BAUD) begin
        meas_ph <= 2'h0;
      end else if (meas_ph == 2'h0) begin
        if (fall) begin
          meas_ph <= 2'h1;
          meas_cnt <= 16'h0001;
        end
      end else if ((meas_ph[0] && rise) || (!meas_ph[0] && fall)) begin
        meas_cnt <= 16'h0001;
        if (meas_ph == 2'h1) begin
          meas_l <= meas_cnt;
          meas_ph <= 2'h2;
        end else if (meas_ph == 2'h2) begin
          meas_h <= meas_cnt;
          meas_ph <= 2'h3;
        end else begin
          // Failed matches are silent and the line is simply re-measured
          meas_ph <= 2'h0;
          if (meas_good) begin
            meas_ok <= 1'b1;
            bit_per <= {1'b0, meas_l[15:1]};
          end
        end
      end else if ((meas_ph == 2'h2 && {2'b00, meas_cnt} > h_hi) ||
                   (meas_ph == 2'h3 && {2'b00, meas_cnt} > l2_hi)) begin
        // An overlong run is no match byte; without this a bad byte left us
        // mid-measurement and the next 0x86 was read out of phase
        meas_ph <= 2'h0;
      end else if (meas_cnt != 16'hffff) begin
        meas_cnt <= meas_cnt + 16'h0001;
      end
    end
  end

  // Receiver at the measured rate, started once the rate is locked
  logic rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bitn;
  logic [7:0] rx_sh;
  boot_resp_pkg::rx_word_t rx;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_bitn <= 4'h0;
      rx_sh <= 8'h00;
      rx <= '0;
    end else begin
      rx.valid <= 1'b0;
      if (!rx_busy) begin
        if (o_locked && fall) begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, bit_per[15:1]};
          rx_bitn <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= bit_per - 16'h0001;
        rx_bitn <= rx_bitn + 4'h1;
        if (rx_bitn == 4'h0) begin
          // A glitch that is gone at mid start bit is no frame
          if (rx_s) begin
            rx_busy <= 1'b0;
          end
        end else if (rx_bitn < boot_resp_pkg::FRAME_BITS - 4'h1) begin
          rx_sh <= {rx_s, rx_sh[7:1]};
        end else begin
          rx_busy <= 1'b0;
          rx.valid <= 1'b1;
          rx.frame_err <= ~rx_s;
          rx.data <= rx_sh;
        end
      end
    end
  end
  wire logic rx_ok = rx.valid && !rx.frame_err;

  // Reply byte selection
  logic [7:0] push_data;
  logic push_valid, push_ready;
  always_comb begin
    push_data = 8'h00;
    case (kind)
      boot_resp_pkg::K_ECHO_BAUD: push_data = boot_resp_pkg::MATCH_BAUD;
      boot_resp_pkg::K_ECHO_SYNC: push_data = boot_resp_pkg::MATCH_SYNC;
      boot_resp_pkg::K_ERR: push_data = err_code;
      boot_resp_pkg::K_SUM: begin
        case (idx)
          5'h00: push_data = sum_hold.blank ? boot_resp_pkg::SUM_BLANK
                                            : boot_resp_pkg::SUM_USED;
          5'h01: push_data = sum_hold.sum[15:8];
          default: push_data = sum_hold.sum[7:0];
        endcase
      end
      boot_resp_pkg::K_ID: begin
        case (idx)
          5'h00: push_data = boot_resp_pkg::CMD_ID;
          5'h01: push_data = boot_resp_pkg::ID_START;
          5'h02: push_data = boot_resp_pkg::ID_COUNT;
          5'h03: push_data = boot_resp_pkg::ID_ADDR_LEN;
          5'h04: push_data = RSV_A;
          5'h08: push_data = ROM_SIZE_CODE;
          5'h09: push_data = boot_resp_pkg::ID_BLOCKS;
          5'h0a: push_data = boot_resp_pkg::FLASH_FIRST[23:16];
          5'h0b: push_data = boot_resp_pkg::FLASH_FIRST[15:8];
          5'h0c: push_data = boot_resp_pkg::FLASH_FIRST[7:0];
          5'h0d: push_data = boot_resp_pkg::FLASH_LAST[23:16];
          5'h0e: push_data = boot_resp_pkg::FLASH_LAST[15:8];
          5'h0f: push_data = boot_resp_pkg::FLASH_LAST[7:0];
          5'h12: push_data = RSV_B;
          5'h14: push_data = RSV_C;
          5'h15: push_data = RSV_D;
          5'h16: push_data = 8'h00 - id_acc;
          default: push_data = boot_resp_pkg::ID_ZERO;
        endcase
      end
      default: push_data = 8'h00;
    endcase
  end
  assign push_valid = (state == boot_resp_pkg::ST_REPLY);
  wire logic push = push_valid && push_ready;
  logic [4:0] last_idx;
  always_comb begin
    case (kind)
      boot_resp_pkg::K_SUM: last_idx = boot_resp_pkg::IDX_SUM_LAST;
      boot_resp_pkg::K_ID: last_idx = boot_resp_pkg::IDX_ID_CSUM;
      boot_resp_pkg::K_ERR: last_idx = boot_resp_pkg::IDX_ERR_LAST;
      default: last_idx = 5'h00;
    endcase
  end

  // Exchange sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= boot_resp_pkg::ST_BAUD;
      kind <= boot_resp_pkg::K_ECHO_BAUD;
      idx <= 5'h00;
      err_code <= boot_resp_pkg::ERR_CMD;
      sum_hold <= '0;
    end else begin
      case (state)
        boot_resp_pkg::ST_BAUD: begin
          if (meas_ok) begin
            state <= boot_resp_pkg::ST_REPLY;
            kind <= boot_resp_pkg::K_ECHO_BAUD;
            idx <= 5'h00;
          end
        end
        boot_resp_pkg::ST_SYNC: begin
          if (rx.valid) begin
            // A wrong second byte is answered with silence and the link stops
            if (rx_ok && rx.data == boot_resp_pkg::MATCH_SYNC) begin
              state <= boot_resp_pkg::ST_REPLY;
              kind <= boot_resp_pkg::K_ECHO_SYNC;
              idx <= 5'h00;
            end else begin
              state <= boot_resp_pkg::ST_HALT;
            end
          end
        end
        boot_resp_pkg::ST_CMD: begin
          if (rx.valid) begin
            state <= boot_resp_pkg::ST_REPLY;
            idx <= 5'h00;
            sum_hold <= i_flash_sum;
            if (rx.frame_err) begin
              kind <= boot_resp_pkg::K_ERR;
              err_code <= boot_resp_pkg::ERR_FRAME;
            end else if (rx.data == boot_resp_pkg::CMD_SUM) begin
              kind <= boot_resp_pkg::K_SUM;
            end else if (rx.data == boot_resp_pkg::CMD_ID) begin
              kind <= boot_resp_pkg::K_ID;
            end else begin
              kind <= boot_resp_pkg::K_ERR;
              err_code <= boot_resp_pkg::ERR_CMD;
            end
          end
        end
        boot_resp_pkg::ST_REPLY: begin
          if (push) begin
            if (idx == last_idx) begin
              idx <= 5'h00;
              case (kind)
                boot_resp_pkg::K_ECHO_BAUD: state <= boot_resp_pkg::ST_SYNC;
                boot_resp_pkg::K_ERR: state <= boot_resp_pkg::ST_HALT;
                default: state <= boot_resp_pkg::ST_CMD;
              endcase
            end else begin
              idx <= idx + 5'h01;
            end
          end
        end
        boot_resp_pkg::ST_HALT: state <= boot_resp_pkg::ST_HALT;
        default: state <= boot_resp_pkg::ST_HALT;
      endcase
    end
  end

  // Identification payload sum, carries beyond bit seven dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      id_acc <= 8'h00;
    end else if (state == boot_resp_pkg::ST_CMD) begin
      id_acc <= 8'h00;
    end else if (push && kind == boot_resp_pkg::K_ID &&
                 idx >= boot_resp_pkg::IDX_ID_PAY_FIRST &&
                 idx <= boot_resp_pkg::IDX_ID_PAY_LAST) begin
      id_acc <= id_acc + push_data;
    end
  end

  assign o_halted = (state == boot_resp_pkg::ST_HALT);
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_locked <= 1'b0;
    end else if (meas_ok) begin
      o_locked <= 1'b1;
    end
  end

  // Two-entry reply buffer; the sequencer stalls while it is full
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PW:0] wr_ptr, rd_ptr;
  wire logic fifo_empty = (wr_ptr == rd_ptr);
  wire logic fifo_full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign push_ready = ~fifo_full;
  logic tx_busy;
  wire logic pop = !fifo_empty && !tx_busy;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
    end else if (push) begin
      fifo_mem[wr_ptr[PW-1:0]] <= push_data;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Transmitter at the measured rate
  logic [9:0] tx_sh;
  logic [15:0] tx_cnt;
  logic [3:0] tx_bitn;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tx_busy <= 1'b0;
      tx_sh <= 10'h3ff;
      tx_cnt <= 16'h0000;
      tx_bitn <= 4'h0;
      o_txd <= 1'b1;
    end else if (pop) begin
      tx_busy <= 1'b1;
      tx_sh <= {1'b1, fifo_mem[rd_ptr[PW-1:0]], 1'b0};
      tx_cnt <= bit_per - 16'h0001;
      tx_bitn <= 4'h0;
      o_txd <= 1'b0;
    end else if (tx_busy) begin
      if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bitn == boot_resp_pkg::FRAME_BITS - 4'h1) begin
        tx_busy <= 1'b0;
        o_txd <= 1'b1;
      end else begin
        tx_cnt <= bit_per - 16'h0001;
        tx_bitn <= tx_bitn + 4'h1;
        tx_sh <= {1'b1, tx_sh[9:1]};
        o_txd <= tx_sh[1];
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence seq_sum_cmd;
    state == boot_resp_pkg::ST_CMD && rx_ok && rx.data == boot_resp_pkg::CMD_SUM;
  endsequence
  sequence seq_sync_ok;
    state == boot_resp_pkg::ST_SYNC && rx_ok && rx.data == boot_resp_pkg::MATCH_SYNC;
  endsequence
  sequence seq_last_err;
    push && kind == boot_resp_pkg::K_ERR && idx == boot_resp_pkg::IDX_ERR_LAST;
  endsequence

  // Payload sum of the fixed record, worked out apart from the running accumulator
  localparam logic [7:0] ID_PAY_SUM = 8'(boot_resp_pkg::ID_ADDR_LEN + RSV_A + ROM_SIZE_CODE +
    boot_resp_pkg::ID_BLOCKS + boot_resp_pkg::FLASH_FIRST[23:16] +
    boot_resp_pkg::FLASH_FIRST[15:8] + boot_resp_pkg::FLASH_FIRST[7:0] +
    boot_resp_pkg::FLASH_LAST[23:16] + boot_resp_pkg::FLASH_LAST[15:8] +
    boot_resp_pkg::FLASH_LAST[7:0] + RSV_B + RSV_C + RSV_D);

  AST_BAUD_ECHO: assert property (meas_ok |=> push_valid &&
    push_data == boot_resp_pkg::MATCH_BAUD)
    else $error("baud echo missing");
  AST_SYNC_ECHO: assert property (seq_sync_ok |=> push_valid &&
    push_data == boot_resp_pkg::MATCH_SYNC)
    else $error("sync echo missing");
  AST_SUM_NO_ECHO: assert property (seq_sum_cmd |=> push_valid &&
    push_data != boot_resp_pkg::CMD_SUM && idx == 5'h00)
    else $error("checksum command echoed");
  AST_ERR_HALT: assert property (seq_last_err |=> o_halted [*3])
    else $error("no idle after error codes");
  AST_HALT_SILENT: assert property (o_halted |=> o_halted && !push_valid)
    else $error("left idle state");
  AST_BLANK_BYTE: assert property (push && kind == boot_resp_pkg::K_SUM &&
    idx == 5'h00 |-> push_data == (sum_hold.blank ? 8'haa : 8'h55))
    else $error("blank byte wrong");
  AST_SUM_ORDER: assert property (push && kind == boot_resp_pkg::K_SUM &&
    idx == 5'h01 |-> push_data == sum_hold.sum[15:8] ##[1:40] push &&
    push_data == sum_hold.sum[7:0])
    else $error("checksum order wrong");
  AST_BACK_TO_CMD: assert property (push && kind == boot_resp_pkg::K_ID &&
    idx == boot_resp_pkg::IDX_ID_CSUM |=> state == boot_resp_pkg::ST_CMD && $stable(o_locked))
    else $error("no return to command");
  AST_ID_ECHO: assert property (push && kind == boot_resp_pkg::K_ID &&
    idx == 5'h00 |-> push_data == 8'hc0)
    else $error("id echo wrong");
  AST_ID_CSUM: assert property (push && kind == boot_resp_pkg::K_ID &&
    idx == boot_resp_pkg::IDX_ID_CSUM |-> push_data == 8'h00 - ID_PAY_SUM)
    else $error("id checksum wrong");
endmodule

// ==== core/boot_resp_pkg.sv ====
// Package with byte codes, reply layout and carrier types of the boot responder
package boot_resp_pkg;
  // Handshake and command bytes
  localparam logic [7:0] MATCH_BAUD = 8'h86;
  localparam logic [7:0] MATCH_SYNC = 8'h79;
  localparam logic [7:0] CMD_SUM = 8'h90;
  localparam logic [7:0] CMD_ID = 8'hc0;
  // Error codes, sent three times; ERR_OVERRUN is never sent
  localparam logic [7:0] ERR_FRAME = 8'ha1;
  localparam logic [7:0] ERR_OVERRUN = 8'ha3;
  localparam logic [7:0] ERR_CMD = 8'h63;
  // Checksum reply
  localparam logic [7:0] SUM_BLANK = 8'haa;
  localparam logic [7:0] SUM_USED = 8'h55;
  // Identification record fixed bytes
  localparam logic [7:0] ID_START = 8'h3a;
  localparam logic [7:0] ID_COUNT = 8'h13;
  localparam logic [7:0] ID_ADDR_LEN = 8'h03;
  localparam logic [7:0] ID_ZERO = 8'h00;
  localparam logic [7:0] ID_BLOCKS = 8'h01;
  localparam logic [23:0] FLASH_FIRST = 24'h001000;
  localparam logic [23:0] FLASH_LAST = 24'h00ffff;
  // Reply positions (index 0 is the first byte the device sends)
  localparam logic [4:0] IDX_ID_PAY_FIRST = 5'h03;
  localparam logic [4:0] IDX_ID_PAY_LAST = 5'h15;
  localparam logic [4:0] IDX_ID_CSUM = 5'h16;
  localparam logic [4:0] IDX_SUM_LAST = 5'h02;
  localparam logic [4:0] IDX_ERR_LAST = 5'h02;
  // Serial framing: start, eight data bits, stop
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [15:0] BIT_PERIOD_RST = 16'h0010;

  typedef enum {ST_BAUD, ST_SYNC, ST_CMD, ST_REPLY, ST_HALT} resp_state_t;
  typedef enum {K_ECHO_BAUD, K_ECHO_SYNC, K_SUM, K_ID, K_ERR} reply_kind_t;

  // Flash checksum supplied by the device, sampled into sum_hold when each command byte arrives
  typedef struct packed {
    logic blank;
    logic [15:0] sum;
  } flash_sum_t;

  // Byte received on the serial line
  typedef struct packed {
    logic valid;
    logic frame_err;
    logic [7:0] data;
  } rx_word_t;
endpackage

// ==== dv/serial_host.sv ====
// Host model for the boot responder: sends framed bytes and collects replies
`timescale 1ns/1ps
module serial_host #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic i_sys_clk,
  // Serial link
  input wire logic i_from_dev,
  output logic o_to_dev
);
  logic [7:0] got[$];
  logic [7:0] shift;

  initial o_to_dev = 1'b1;

  // Every frame uses the one host rate that the device measured from 0x86
  // Bench calls this only once the previous answer is in, never mid-reply
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] frame;
    frame = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_to_dev = frame[i];
      repeat (BIT) @(negedge i_sys_clk);
    end
    o_to_dev = 1'b1;
  endtask

  // Mid-bit sampling at the host rate, LSB first
  // Falling edges only: the line is launched on the rising edge and settled by then
  always begin
    @(negedge i_sys_clk);
    if (i_from_dev === 1'b0) begin
      repeat (BIT / 2) @(negedge i_sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge i_sys_clk);
        shift[i] = i_from_dev;
      end
      repeat (BIT) @(negedge i_sys_clk);
      got.push_back(shift);
    end
  end
endmodule

// ==== dv/boot_serial_sum_and_id_responder_test.sv ====
// Self-checking bench for the boot serial responder
`timescale 1ns/1ps
module boot_serial_sum_and_id_responder_test;
  localparam int BIT = 16; // Same as the host model's default bit time
  localparam logic [7:0] ROM_CODE = 8'h2b; // Arbitrary value
  localparam logic [7:0] RA = 8'h17; // Arbitrary value
  localparam logic [7:0] RB = 8'h4e; // Arbitrary value
  localparam logic [7:0] RC = 8'h9c; // Arbitrary value
  localparam logic [7:0] RD = 8'hd3; // Arbitrary value
  logic i_sys_clk;
  logic i_reset;
  logic rxd;
  logic o_txd;
  boot_resp_pkg::flash_sum_t i_flash_sum;
  logic o_locked;
  logic o_halted;
  int miscompares;
  int checks;
  int r;
  logic [7:0] exp[$];

  boot_resp #(.ROM_SIZE_CODE(ROM_CODE), .RSV_A(RA), .RSV_B(RB), .RSV_C(RC),
    .RSV_D(RD)) i_dut (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_rxd(rxd),
    .o_txd(o_txd),
    .i_flash_sum(i_flash_sum),
    .o_locked(o_locked),
    .o_halted(o_halted)
  );

  serial_host i_host (
    .i_sys_clk(i_sys_clk),
    .i_from_dev(o_txd),
    .o_to_dev(rxd)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  task automatic check_byte(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic check_flag(input logic got, input logic want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Sends one byte, waits for the whole answer, then a quiet gap to catch extras
  task automatic xfer(input logic [7:0] b, input logic stop, input string name);
    int n;
    i_host.send_byte(b, stop);
    n = 0;
    while (i_host.got.size() < exp.size() && n < 6000) begin
      @(negedge i_sys_clk);
      n++;
    end
    repeat (30 * BIT) @(negedge i_sys_clk);
    check_byte(8'(i_host.got.size()), 8'(exp.size()));
    while (exp.size() > 0 && i_host.got.size() > 0) begin
      check_byte(i_host.got.pop_front(), exp.pop_front());
    end
    exp.delete();
    i_host.got.delete();
    $display("test %s done", name);
  endtask

  task automatic do_reset;
    i_reset = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_reset = 1'b0;
  endtask

  task automatic link_up;
    exp.push_back(boot_resp_pkg::MATCH_BAUD);
    xfer(boot_resp_pkg::MATCH_BAUD, 1'b1, "baud");
    check_flag(o_locked, 1'b1);
    exp.push_back(boot_resp_pkg::MATCH_SYNC);
    xfer(boot_resp_pkg::MATCH_SYNC, 1'b1, "sync");
  endtask

  task automatic sum_cmd(input logic blank);
    i_flash_sum.sum = 16'($urandom);
    i_flash_sum.blank = blank;
    exp.push_back(blank ? 8'haa : 8'h55);
    exp.push_back(i_flash_sum.sum[15:8]);
    exp.push_back(i_flash_sum.sum[7:0]);
    xfer(boot_resp_pkg::CMD_SUM, 1'b1, "sum");
  endtask

  task automatic id_cmd;
    logic [7:0] pay[19];
    int s;
    pay = '{8'h03, RA, 8'h00, 8'h00, 8'h00, ROM_CODE, 8'h01, 8'h00, 8'h10, 8'h00,
      8'h00, 8'hff, 8'hff, 8'h00, 8'h00, RB, 8'h00, RC, RD};
    s = 0;
    exp.push_back(8'hc0);
    exp.push_back(8'h3a);
    exp.push_back(8'h13);
    foreach (pay[i]) begin
      exp.push_back(pay[i]);
      s += pay[i];
    end
    exp.push_back(8'(-s));
    xfer(boot_resp_pkg::CMD_ID, 1'b1, "id");
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is near 19k cycles; five times that means a hang
  initial begin
    #1_000_000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    i_sys_clk = 1'b0;
    i_reset = 1'b1;
    i_flash_sum = '0;
    miscompares = 0;
    checks = 0;
    r = $urandom(32'h269e);
    repeat (2) @(negedge i_sys_clk);
    i_reset = 1'b0;
    check_flag(o_txd, 1'b1);
    check_flag(o_halted, 1'b0);
    // Runs of the wrong proportions must not lock the rate
    xfer(8'h80, 1'b1, "bad_baud");
    check_flag(o_locked, 1'b0);
    link_up();
    sum_cmd(1'b1);
    id_cmd();
    sum_cmd(1'b0);
    id_cmd();
    // Loader command is unknown here: error code thrice, then idle
    repeat (3) exp.push_back(8'h63);
    xfer(8'h40, 1'b1, "loader");
    check_flag(o_halted, 1'b1);
    xfer(boot_resp_pkg::CMD_SUM, 1'b1, "halted");
    do_reset();
    check_flag(o_halted, 1'b0);
    link_up();
    repeat (3) exp.push_back(8'ha1);
    xfer(8'($urandom), 1'b0, "frame_err");
    check_flag(o_halted, 1'b1);
    do_reset();
    exp.push_back(boot_resp_pkg::MATCH_BAUD);
    xfer(boot_resp_pkg::MATCH_BAUD, 1'b1, "baud2");
    xfer(8'h78, 1'b1, "bad_sync");
    check_flag(o_halted, 1'b1);
    tally_and_finish();
  end
endmodule
